// ---- sbs_cycle_decode.sv ----
// sbs_cycle_decode: per-edge cycle decode and data pin enable control
// assumes all synchronous inputs come from logic on mclk; output enable and
// sleep request are asynchronous pins and are synchronised here where clocked
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - write when global low or gated lane low
// - no write when all write inputs high
// - processor strobe with select always reads
// - writes only after processor strobe or controller
// - output enable unregistered, masked during writes
// - read drives data only with enable low
// - processor strobe selected begins read burst
// - controller strobe selected begins burst, qualified
// - no strobes, advance low continues burst
// - no strobes, advance high suspends burst
// - decode four lanes, global writes all
// - sleep ignores inputs, two cycles transition
// - deselect tri-states data outputs immediately
module sbs_cycle_decode (
	input  wire logic                              mclk,
	input  wire logic                              sys_rst,
	input  wire sbs_pkg::sbs_ctrl_t                ctrl,
	input  wire logic                              sleep_request,
	input  wire logic                              out_enable_n,
	output sbs_pkg::sbs_cycle_t                    cycle_q,
	output logic                                   cycle_valid_q,
	output logic                                   asleep_q,
	output logic [sbs_pkg::SBS_LANES-1:0]          data_oe_n,
	output logic [sbs_pkg::SBS_LANES-1:0]          parity_oe_n
);
	// ==========================================
	// sleep pin synchroniser
	logic sleep_s1_q;  // first stage, read only by second
	logic sleep_s2_q;  // synchronised sleep request

	// two flops before any logic
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sleep_s1_q <= 1'b0;
			sleep_s2_q <= 1'b0;
		end else begin
			sleep_s1_q <= sleep_request;
			sleep_s2_q <= sleep_s1_q;
		end
	end

	// ==========================================
	// sleep entry and exit counter
	logic [1:0] sleep_cnt_q;  // cycles spent toward target state
	logic       sleep_busy;   // entering, asleep, or recovering

	// two cycles to settle either way
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sleep_cnt_q <= sbs_pkg::SBS_SLEEP_CNT_RST;
			asleep_q    <= 1'b0;
		end else if (sleep_s2_q != asleep_q) begin
			if (sleep_cnt_q == sbs_pkg::SBS_SLEEP_CNT_MAX - 2'h1) begin
				asleep_q    <= sleep_s2_q;
				sleep_cnt_q <= sbs_pkg::SBS_SLEEP_CNT_RST;
			end else begin
				sleep_cnt_q <= sleep_cnt_q + 2'h1;
			end
		end else begin
			sleep_cnt_q <= sbs_pkg::SBS_SLEEP_CNT_RST;
		end
	end
	// inputs ignored while entering, asleep or leaving
	assign sleep_busy = asleep_q | sleep_s2_q;

	// ==========================================
	// write qualifier and lane decode
	logic                          write_n;   // internal write qualifier, low = write
	logic [sbs_pkg::SBS_LANES-1:0] lanes_d;   // lanes written this edge

	// combine global, gate and lane enables
	always_comb begin
		if (!ctrl.global_write_n) begin
			lanes_d = '1;
		end else if (!ctrl.byte_write_gate_n) begin
			lanes_d = ~ctrl.lane_write_n;
		end else begin
			lanes_d = '0;
		end
		write_n = ~(|lanes_d);
	end

	// ==========================================
	// operation decode
	logic selected;       // all three selects active
	logic strobe_any;     // controller strobe low, or processor strobe with first select low
	logic proc_valid;     // processor strobe counts only with first select low
	sbs_pkg::sbs_cycle_t cycle_d;

	assign selected   = ~ctrl.chip_sel_first_n & ctrl.chip_sel_second
		& ~ctrl.chip_sel_third_n;
	assign proc_valid = ~ctrl.processor_addr_strobe_n & ~ctrl.chip_sel_first_n;
	assign strobe_any = proc_valid | ~ctrl.controller_addr_strobe_n;

	// priority: sleep, strobes, then burst continue or suspend
	always_comb begin
		cycle_d.op       = sbs_pkg::SBS_OP_DESELECT;
		cycle_d.is_write = 1'b0;
		cycle_d.lanes_wr = '0;
		if (sleep_busy) begin
			cycle_d.op = sbs_pkg::SBS_OP_SLEEP;
		end else if (strobe_any && !selected) begin
			cycle_d.op = sbs_pkg::SBS_OP_DESELECT;
		end else if (proc_valid) begin
			cycle_d.op = sbs_pkg::SBS_OP_BEGIN;
		end else if (!ctrl.controller_addr_strobe_n) begin
			cycle_d.op       = sbs_pkg::SBS_OP_BEGIN;
			cycle_d.is_write = ~write_n;
			cycle_d.lanes_wr = lanes_d;
		end else if (!ctrl.burst_step_n) begin
			cycle_d.op       = sbs_pkg::SBS_OP_CONTINUE;
			cycle_d.is_write = ~write_n;
			cycle_d.lanes_wr = lanes_d;
		end else begin
			cycle_d.op       = sbs_pkg::SBS_OP_SUSPEND;
			cycle_d.is_write = ~write_n;
			cycle_d.lanes_wr = lanes_d;
		end
	end

	// ==========================================
	// cycle register and active-burst tracking
	logic active_q;  // device holds a selected cycle

	// register decoded cycle each edge
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cycle_q       <= '{op: sbs_pkg::SBS_OP_DESELECT, is_write: 1'b0, lanes_wr: '0};
			cycle_valid_q <= 1'b0;
		end else begin
			cycle_q       <= cycle_d;
			cycle_valid_q <= cycle_d.op != sbs_pkg::SBS_OP_DESELECT
				&& cycle_d.op != sbs_pkg::SBS_OP_SLEEP;
		end
	end

	// continue and suspend keep the prior selection state
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			active_q <= 1'b0;
		end else if (cycle_d.op == sbs_pkg::SBS_OP_DESELECT
			|| cycle_d.op == sbs_pkg::SBS_OP_SLEEP) begin
			active_q <= 1'b0;
		end else if (cycle_d.op == sbs_pkg::SBS_OP_BEGIN) begin
			active_q <= 1'b1;
		end
	end

	// ==========================================
	// data pin enables, low = driving
	logic drive;  // read cycle with output enable low

	// output enable used directly, never clocked
	assign drive       = active_q && !cycle_q.is_write && !asleep_q
		&& !out_enable_n;
	assign data_oe_n   = {sbs_pkg::SBS_LANES{~drive}};
	assign parity_oe_n = {sbs_pkg::SBS_LANES{~drive}};

	// ==========================================
	// checks
	property p_proc_read;
		@(posedge mclk) disable iff (sys_rst)
		(!sleep_busy && selected && !ctrl.processor_addr_strobe_n)
			|=> (cycle_q.op == sbs_pkg::SBS_OP_BEGIN && !cycle_q.is_write);
	endproperty
	a_proc_read: assert property (p_proc_read) else $error("strobe did not read");

	property p_gw_all;
		@(posedge mclk) disable iff (sys_rst)
		(!sleep_busy && ctrl.processor_addr_strobe_n && !ctrl.controller_addr_strobe_n
			&& selected && !ctrl.global_write_n)
			|=> (cycle_q.is_write && cycle_q.lanes_wr == '1);
	endproperty
	a_gw_all: assert property (p_gw_all) else $error("global write lanes wrong");

	property p_no_write;
		@(posedge mclk) disable iff (sys_rst)
		(ctrl.global_write_n && ctrl.byte_write_gate_n) |=> !cycle_q.is_write;
	endproperty
	a_no_write: assert property (p_no_write) else $error("write without enables");

	property p_lane_write;
		@(posedge mclk) disable iff (sys_rst)
		(!sleep_busy && ctrl.processor_addr_strobe_n && ctrl.controller_addr_strobe_n
			&& ctrl.global_write_n && !ctrl.byte_write_gate_n && ctrl.lane_write_n != '1)
			|=> (cycle_q.is_write && cycle_q.lanes_wr == ~$past(ctrl.lane_write_n));
	endproperty
	a_lane_write: assert property (p_lane_write) else $error("lane write missed");

	property p_continue;
		@(posedge mclk) disable iff (sys_rst)
		(!sleep_busy && ctrl.processor_addr_strobe_n && ctrl.controller_addr_strobe_n)
			|=> (cycle_q.op == ($past(ctrl.burst_step_n) ? sbs_pkg::SBS_OP_SUSPEND
				: sbs_pkg::SBS_OP_CONTINUE));
	endproperty
	a_continue: assert property (p_continue) else $error("burst step wrong");

	property p_deselect;
		@(posedge mclk) disable iff (sys_rst)
		(!sleep_busy && !ctrl.controller_addr_strobe_n && !selected)
			|=> (data_oe_n == '1 && cycle_q.op == sbs_pkg::SBS_OP_DESELECT);
	endproperty
	a_deselect: assert property (p_deselect) else $error("deselect still drives");

	// a begun write masks output enable on the next cycle, whatever its level
	property p_write_hiz;
		@(posedge mclk) disable iff (sys_rst)
		(!sleep_busy && selected && ctrl.processor_addr_strobe_n
			&& !ctrl.controller_addr_strobe_n && (!ctrl.global_write_n
			|| (!ctrl.byte_write_gate_n && ctrl.lane_write_n != '1)))
			|=> (data_oe_n == '1 && parity_oe_n == '1);
	endproperty
	a_write_hiz: assert property (p_write_hiz) else $error("driving in write");

	property p_sleep_enter;
		@(posedge mclk) disable iff (sys_rst)
		(sleep_s2_q && !asleep_q && $past(!sleep_s2_q)) |=> !asleep_q ##1 asleep_q;
	endproperty
	a_sleep_enter: assert property (p_sleep_enter) else $error("sleep entry timing");

	property p_read_drive;
		@(posedge mclk) disable iff (sys_rst)
		(!sleep_busy && selected && !ctrl.processor_addr_strobe_n) ##1 !out_enable_n
			|-> (data_oe_n == '0 && parity_oe_n == '0);
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not driving");

	c_write_burst: cover property (@(posedge mclk) disable iff (sys_rst)
		cycle_q.op == sbs_pkg::SBS_OP_BEGIN && cycle_q.is_write
		##1 cycle_q.op == sbs_pkg::SBS_OP_CONTINUE);
	c_read_drive: cover property (@(posedge mclk) disable iff (sys_rst) data_oe_n == '0);
	c_suspend: cover property (@(posedge mclk) disable iff (sys_rst)
		cycle_q.op == sbs_pkg::SBS_OP_SUSPEND);
	c_sleep: cover property (@(posedge mclk) disable iff (sys_rst) asleep_q);
endmodule : sbs_cycle_decode
`default_nettype wire

// ---- sbs_master_model.sv ----
// sbs_master_model: bus master model driving the sram control pins
// assumes drive is called just after a falling mclk edge
`timescale 1ns/1ps
`default_nettype none
module sbs_master_model (
	output sbs_pkg::sbs_ctrl_t ctrl,
	output logic               sleep_request,
	output logic               out_enable_n
);
	// ==========================================
	// one bus cycle of control pins
	task automatic drive(input sbs_pkg::sbs_ctrl_t c, input logic oe_n, input logic slp);
		ctrl = c;
		sleep_request = slp;
		// output enable parked high whenever a write is qualified
		out_enable_n = oe_n | !c.global_write_n |
			(!c.byte_write_gate_n & !(&c.lane_write_n));
	endtask : drive
endmodule : sbs_master_model
`default_nettype wire

// ---- sbs_pkg.sv ----
// sbs_pkg: shared types and constants for the burst sram cycle decoder
// assumes a single 40 MHz clock domain; no software-visible registers
package sbs_pkg;
	// ==========================================
	// widths and timing
	localparam int          SBS_LANES       = 4;     // byte lanes, wide configuration
	localparam int          SBS_BYTE_W      = 8;     // data bits per lane
	localparam int          SBS_CLK_PERIOD_NS = 25;  // mclk period
	localparam int          SBS_SLEEP_CYCLES = 2;    // cycles to enter or leave sleep
	localparam logic [1:0]  SBS_SLEEP_CNT_RST = 2'h0; // sleep counter reset value
	localparam logic [1:0]  SBS_SLEEP_CNT_MAX = 2'(SBS_SLEEP_CYCLES); // count limit; transition taken at one below it

	// ==========================================
	// decoded operation per clock edge
	typedef enum logic [2:0] {
		SBS_OP_DESELECT,
		SBS_OP_SLEEP,
		SBS_OP_BEGIN,
		SBS_OP_CONTINUE,
		SBS_OP_SUSPEND
	} sbs_op_t;

	// synchronous control pins as one bundle
	typedef struct packed {
		logic                 chip_sel_first_n;        // address-pipelining select
		logic                 chip_sel_second;         // depth select, active high
		logic                 chip_sel_third_n;        // depth select, active low
		logic                 processor_addr_strobe_n; // processor strobe
		logic                 controller_addr_strobe_n;// controller strobe
		logic                 burst_step_n;            // burst advance
		logic                 global_write_n;          // write all lanes
		logic                 byte_write_gate_n;       // enables lane writes
		logic [SBS_LANES-1:0] lane_write_n;            // per-lane write enables
	} sbs_ctrl_t;

	// decoded cycle result
	typedef struct packed {
		sbs_op_t              op;        // operation class
		logic                 is_write;  // write cycle
		logic [SBS_LANES-1:0] lanes_wr;  // lanes written, active high
	} sbs_cycle_t;
endpackage : sbs_pkg

// ---- sync_burst_sram_cycle_decode_bench.sv ----
// sync_burst_sram_cycle_decode_bench: random and directed cycle decode checks
// assumes sbs_pkg, sbs_cycle_decode and sbs_master_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_cycle_decode_bench;
	// ==========================================
	// signals
	logic                mclk, sys_rst, sleep_request, out_enable_n;
	logic                cycle_valid_q, asleep_q, act; // act: expected active burst
	logic [3:0]          data_oe_n, parity_oe_n, eoe;
	sbs_pkg::sbs_ctrl_t  ctrl, c;
	sbs_pkg::sbs_cycle_t cycle_q, e;
	int                  mismatches, total_checks, cycles;

	sbs_cycle_decode sbs_cycle_decode_inst (.mclk(mclk), .sys_rst(sys_rst), .ctrl(ctrl),
		.sleep_request(sleep_request), .out_enable_n(out_enable_n), .cycle_q(cycle_q),
		.cycle_valid_q(cycle_valid_q), .asleep_q(asleep_q), .data_oe_n(data_oe_n),
		.parity_oe_n(parity_oe_n));
	sbs_master_model sbs_master_model_inst (.ctrl(ctrl), .sleep_request(sleep_request),
		.out_enable_n(out_enable_n));

	// ==========================================
	// expected decode of one edge
	function automatic sbs_pkg::sbs_cycle_t exp_cycle(input sbs_pkg::sbs_ctrl_t c);
		sbs_pkg::sbs_cycle_t r;
		logic                sel;
		sel = !c.chip_sel_first_n && c.chip_sel_second && !c.chip_sel_third_n;
		r.lanes_wr = !c.global_write_n ? 4'hf : !c.byte_write_gate_n ? ~c.lane_write_n : 4'h0;
		r.is_write = |r.lanes_wr;
		if (!c.processor_addr_strobe_n && !c.chip_sel_first_n) begin
			r.op = sel ? sbs_pkg::SBS_OP_BEGIN : sbs_pkg::SBS_OP_DESELECT;
			r.is_write = 1'b0; // processor strobe always reads
			r.lanes_wr = 4'h0;
		end else if (!c.controller_addr_strobe_n)
			r.op = sel ? sbs_pkg::SBS_OP_BEGIN : sbs_pkg::SBS_OP_DESELECT;
		else
			r.op = c.burst_step_n ? sbs_pkg::SBS_OP_SUSPEND : sbs_pkg::SBS_OP_CONTINUE;
		// a deselect carries no write
		if (r.op == sbs_pkg::SBS_OP_DESELECT) begin
			r.is_write = 1'b0;
			r.lanes_wr = 4'h0;
		end
		return r;
	endfunction : exp_cycle

	// ==========================================
	// compare and close
	task automatic check(input string n, input logic [3:0] x, input logic [3:0] g);
		total_checks++;
		if (g !== x) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask : check

	task automatic finish_test();
		if (mismatches == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	// one decoded cycle: drive, let the edge pass, compare
	task automatic step(input sbs_pkg::sbs_ctrl_t c, input logic oe_n);
		sbs_master_model_inst.drive(c, oe_n, 1'b0);
		e = exp_cycle(c);
		@(negedge mclk);
		check("op", 4'(e.op), 4'(cycle_q.op));
		check("valid", 4'(e.op != sbs_pkg::SBS_OP_DESELECT), 4'(cycle_valid_q));
		check("write", 4'(e.is_write), 4'(cycle_q.is_write));
		check("lanes", e.lanes_wr, cycle_q.lanes_wr);
		if (e.op == sbs_pkg::SBS_OP_BEGIN) act = 1'b1;
		if (e.op == sbs_pkg::SBS_OP_DESELECT) act = 1'b0;
		eoe = {4{~(act && !e.is_write && !out_enable_n)}};
		check("data_oe", eoe, data_oe_n);
		check("parity_oe", eoe, parity_oe_n);
	endtask : step

	// ==========================================
	// clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 1000) begin
			mismatches++;
			finish_test();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		void'($urandom(32'hf5d0));
		mismatches = 0;
		total_checks = 0;
		cycles = 0;
		act = 1'b0;
		sys_rst = 1'b1;
		sbs_master_model_inst.drive('1, 1'b1, 1'b0);
		repeat (8) @(negedge mclk);
		sys_rst = 1'b0;
		@(negedge mclk);
		// processor begin, then a continued global write
		c = '1;
		c.chip_sel_first_n = 1'b0;
		c.chip_sel_third_n = 1'b0;
		c.processor_addr_strobe_n = 1'b0;
		c.global_write_n = 1'b0;
		step(c, 1'b0);
		c = '1;
		c.burst_step_n = 1'b0;
		c.global_write_n = 1'b0;
		step(c, 1'b0);
		// every lane pattern on controller begins
		for (int i = 0; i < 16; i++) begin
			c = '1;
			{c.chip_sel_first_n, c.chip_sel_third_n, c.controller_addr_strobe_n} = 3'h0;
			c.byte_write_gate_n = 1'b0;
			c.lane_write_n = 4'(i);
			step(c, 1'b0);
		end
		// random traffic, selects often all active
		repeat (500) begin
			c = sbs_pkg::sbs_ctrl_t'(12'($urandom));
			if ($urandom % 2 == 0)
				{c.chip_sel_first_n, c.chip_sel_second, c.chip_sel_third_n} = 3'b010;
			step(c, 1'($urandom));
		end
		// mid-run reset drops any open burst and releases the pins
		sys_rst = 1'b1;
		sbs_master_model_inst.drive('1, 1'b0, 1'b0);
		repeat (2) @(negedge mclk);
		check("op", 4'(sbs_pkg::SBS_OP_DESELECT), 4'(cycle_q.op));
		check("valid", 4'h0, 4'(cycle_valid_q));
		check("data_oe", 4'hf, data_oe_n);
		sys_rst = 1'b0;
		act = 1'b0;
		@(negedge mclk);
		// deselect, then sleep with enable low
		c = '1;
		c.controller_addr_strobe_n = 1'b0;
		step(c, 1'b0);
		sbs_master_model_inst.drive('1, 1'b0, 1'b1);
		repeat (3) @(negedge mclk);
		check("asleep", 4'h0, {3'h0, asleep_q});
		@(negedge mclk);
		check("asleep", 4'h1, {3'h0, asleep_q});
		check("op", 4'(sbs_pkg::SBS_OP_SLEEP), 4'(cycle_q.op));
		check("data_oe", 4'hf, data_oe_n);
		sbs_master_model_inst.drive('1, 1'b0, 1'b0);
		repeat (3) @(negedge mclk);
		check("asleep", 4'h1, {3'h0, asleep_q});
		@(negedge mclk);
		check("asleep", 4'h0, {3'h0, asleep_q});
		act = 1'b0;
		repeat (2) @(negedge mclk);
		finish_test();
	end
endmodule : sync_burst_sram_cycle_decode_bench
`default_nettype wire
